// ==== shared/incdec_pkg.sv ====
// Shared constants, opcode codes and state type of the increment, skip, jump and OR executor.
package incdec_pkg;

    localparam int unsigned REF_CLK_HZ        = 25_000_000;
    localparam int unsigned CLKS_PER_INSTR    = 4;

    localparam int unsigned DATA_W            = 8;
    localparam int unsigned FADDR_W           = 7;
    localparam int unsigned JUMP_W            = 11;
    localparam int unsigned PC_W              = 15;
    localparam int unsigned LATCH_W           = 7;
    localparam int unsigned LATCH_LO          = 3;
    localparam int unsigned LATCH_HI          = 6;
    localparam int unsigned OP_W              = 3;

    localparam logic [OP_W-1:0] OP_NONE       = 3'h0;
    localparam logic [OP_W-1:0] OP_DEC_SKIP   = 3'h1;
    localparam logic [OP_W-1:0] OP_INC_SKIP   = 3'h2;
    localparam logic [OP_W-1:0] OP_INC_FILE   = 3'h3;
    localparam logic [OP_W-1:0] OP_JUMP       = 3'h4;
    localparam logic [OP_W-1:0] OP_OR_LIT     = 3'h5;
    localparam logic [OP_W-1:0] OP_OR_FILE    = 3'h6;

    localparam logic            DEST_ACC      = 1'b0;
    localparam logic            DEST_FILE     = 1'b1;

    localparam logic [DATA_W-1:0] ACC_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ONE    = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;
    localparam logic [FADDR_W-1:0] FADDR_RESET = 7'h00;
    localparam logic [PC_W-1:0]   PC_RESET    = 15'h0000;
    localparam logic [PC_W-1:0]   PC_STEP     = 15'h0001;
    localparam logic              ZERO_RESET  = 1'b0;

    typedef enum logic [1:0] {
        ST_EXEC,
        ST_SKIP_NOP,
        ST_JUMP_NOP
    } incdec_state_t;

endpackage : incdec_pkg

// ==== src/incdec_alu.sv ====
// Combinational result unit for the increment, decrement and OR operations.
`timescale 1ns/1ns
module incdec_alu
    import incdec_pkg::*;
(
    input  wire logic [OP_W-1:0]   op_i,
    input  wire logic [DATA_W-1:0] acc_i,
    input  wire logic [DATA_W-1:0] file_i,
    input  wire logic [DATA_W-1:0] literal_i,
    output logic      [DATA_W-1:0] result_o,
    output logic                   result_zero_o
);

    always_comb begin
        result_o = file_i;
        unique case (op_i)
            OP_DEC_SKIP: begin
                result_o = file_i - DATA_ONE;
            end
            OP_INC_SKIP, OP_INC_FILE: begin
                result_o = file_i + DATA_ONE;
            end
            OP_OR_LIT: begin
                result_o = acc_i | literal_i;
            end
            OP_OR_FILE: begin
                result_o = acc_i | file_i;
            end
            default: begin
                result_o = file_i;
            end
        endcase
        result_zero_o = (result_o == DATA_ZERO);
    end

endmodule : incdec_alu

// ==== src/incdec_exec.sv ====
// Executor for increment, skip-if-null, unconditional jump and OR instructions.
`timescale 1ns/1ns
module incdec_exec
    import incdec_pkg::*;
#(
    parameter int unsigned CLKS_PER_SLOT = CLKS_PER_INSTR
)(
    input  wire logic               REF_CLK_I,
    input  wire logic               RST_N_I,
    input  wire logic               EXEC_VALID_I,
    input  wire logic [OP_W-1:0]    OPCODE_I,
    input  wire logic [FADDR_W-1:0] FILE_ADDR_I,
    input  wire logic               DEST_SEL_I,
    input  wire logic [JUMP_W-1:0]  LITERAL_I,
    input  wire logic [DATA_W-1:0]  FILE_RDATA_I,
    input  wire logic [LATCH_W-1:0] PC_HIGH_LATCH_I,
    output logic                    INSTR_TICK_O,
    output logic                    INSTR_ACCEPT_O,
    output logic                    NOP_SLOT_O,
    output logic [DATA_W-1:0]       ACC_O,
    output logic                    ZERO_FLAG_O,
    output logic [PC_W-1:0]         PC_O,
    output logic                    FILE_WE_O,
    output logic [FADDR_W-1:0]      FILE_WADDR_O,
    output logic [DATA_W-1:0]       FILE_WDATA_O
);

    localparam int unsigned CNT_W     = $clog2(CLKS_PER_SLOT);
    localparam int          SLOT_WAIT = CLKS_PER_SLOT;
    localparam logic [CNT_W-1:0] CNT_LAST  = CNT_W'(CLKS_PER_SLOT - 1);
    localparam logic [CNT_W-1:0] CNT_RESET = '0;
    localparam logic [CNT_W-1:0] CNT_STEP  = CNT_W'(1);

    if (CLKS_PER_SLOT < 2 || CLKS_PER_SLOT > 64) begin : g_slot_check
        $error("CLKS_PER_SLOT must lie between 2 and 64");
    end

    typedef struct packed {
        logic [CNT_W-1:0]   div_cnt;
        incdec_state_t      state;
        logic [DATA_W-1:0]  acc;
        logic               zero;
        logic [PC_W-1:0]    pc;
        logic               file_we;
        logic [FADDR_W-1:0] file_waddr;
        logic [DATA_W-1:0]  file_wdata;
    } incdec_regs_t;

    incdec_regs_t            s_q;
    incdec_regs_t            s_d;
    logic                    instr_tick;
    logic                    accept;
    logic [DATA_W-1:0]       alu_res;
    logic                    alu_zero;
    logic [PC_W-1:0]         jump_target;
    logic                    skip_op;

    incdec_alu u_alu (
        .op_i          (OPCODE_I),
        .acc_i         (s_q.acc),
        .file_i        (FILE_RDATA_I),
        .literal_i     (LITERAL_I[DATA_W-1:0]),
        .result_o      (alu_res),
        .result_zero_o (alu_zero)
    );

    assign instr_tick  = (s_q.div_cnt == CNT_LAST);
    assign accept      = instr_tick && (s_q.state == ST_EXEC);
    assign skip_op     = (OPCODE_I == OP_DEC_SKIP) || (OPCODE_I == OP_INC_SKIP);
    assign jump_target = {PC_HIGH_LATCH_I[LATCH_HI:LATCH_LO], LITERAL_I};

    always_comb begin
        s_d         = s_q;
        s_d.file_we = 1'b0;
        s_d.div_cnt = instr_tick ? CNT_RESET : s_q.div_cnt + CNT_STEP;
        if (instr_tick) begin
            unique case (s_q.state)
                ST_EXEC: begin
                    if (EXEC_VALID_I) begin
                        s_d.pc = s_q.pc + PC_STEP;
                        unique case (OPCODE_I)
                            OP_DEC_SKIP, OP_INC_SKIP: begin
                                if (DEST_SEL_I == DEST_ACC) begin
                                    s_d.acc = alu_res;
                                end else begin
                                    s_d.file_we    = 1'b1;
                                    s_d.file_waddr = FILE_ADDR_I;
                                    s_d.file_wdata = alu_res;
                                end
                                if (alu_zero) begin
                                    s_d.state = ST_SKIP_NOP;
                                end else begin
                                    s_d.state = ST_EXEC;
                                end
                            end
                            OP_INC_FILE, OP_OR_FILE: begin
                                if (DEST_SEL_I == DEST_ACC) begin
                                    s_d.acc = alu_res;
                                end else begin
                                    s_d.file_we    = 1'b1;
                                    s_d.file_waddr = FILE_ADDR_I;
                                    s_d.file_wdata = alu_res;
                                end
                                s_d.zero = alu_zero;
                            end
                            OP_OR_LIT: begin
                                s_d.acc  = alu_res;
                                s_d.zero = alu_zero;
                            end
                            OP_JUMP: begin
                                s_d.pc    = jump_target;
                                s_d.state = ST_JUMP_NOP;
                            end
                            default: begin
                                s_d.state = ST_EXEC;
                            end
                        endcase
                    end
                end
                ST_SKIP_NOP: begin
                    s_d.pc    = s_q.pc + PC_STEP;
                    s_d.state = ST_EXEC;
                end
                ST_JUMP_NOP: begin
                    s_d.state = ST_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s_q.div_cnt    <= CNT_RESET;
            s_q.state      <= ST_EXEC;
            s_q.acc        <= ACC_RESET;
            s_q.zero       <= ZERO_RESET;
            s_q.pc         <= PC_RESET;
            s_q.file_we    <= 1'b0;
            s_q.file_waddr <= FADDR_RESET;
            s_q.file_wdata <= DATA_ZERO;
        end else begin
            s_q <= s_d;
        end
    end

    assign INSTR_TICK_O   = instr_tick;
    assign INSTR_ACCEPT_O = accept;
    assign NOP_SLOT_O     = instr_tick && (s_q.state != ST_EXEC);
    assign ACC_O          = s_q.acc;
    assign ZERO_FLAG_O    = s_q.zero;
    assign PC_O           = s_q.pc;
    assign FILE_WE_O      = s_q.file_we;
    assign FILE_WADDR_O   = s_q.file_waddr;
    assign FILE_WDATA_O   = s_q.file_wdata;

    chk_dec_to_acc: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_DEC_SKIP && DEST_SEL_I == DEST_ACC
        |=> ACC_O == $past(FILE_RDATA_I) - DATA_ONE && !FILE_WE_O
    ) else $error("Decrement result did not reach the accumulator.");

    chk_dec_to_file: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_DEC_SKIP && DEST_SEL_I == DEST_FILE
        |=> FILE_WE_O && FILE_WADDR_O == $past(FILE_ADDR_I)
            && FILE_WDATA_O == $past(FILE_RDATA_I) - DATA_ONE && $stable(ACC_O)
    ) else $error("Decrement result did not reach the file register.");

    chk_skip_null_nop: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && skip_op && alu_zero
        |-> ##SLOT_WAIT NOP_SLOT_O && !INSTR_ACCEPT_O
    ) else $error("Zero skip result did not insert a no-operation slot.");

    chk_skip_nonzero: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && skip_op && !alu_zero
        |-> ##SLOT_WAIT INSTR_ACCEPT_O && !NOP_SLOT_O
    ) else $error("Nonzero skip result suppressed the next instruction.");

    chk_inc_skip_route: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_INC_SKIP
        |=> (FILE_WE_O ? FILE_WDATA_O : ACC_O) == $past(FILE_RDATA_I) + DATA_ONE
            && FILE_WE_O == $past(DEST_SEL_I) && $stable(ZERO_FLAG_O)
    ) else $error("Increment-skip result or routing is wrong.");

    chk_inc_zero_flag: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_INC_FILE
        |=> ZERO_FLAG_O == ($past(FILE_RDATA_I) == 8'hff)
            && FILE_WE_O == $past(DEST_SEL_I)
    ) else $error("Increment did not update the zero flag correctly.");

    chk_jump_target: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_JUMP
        |=> PC_O[JUMP_W-1:0] == $past(LITERAL_I)
            && PC_O[PC_W-1:JUMP_W] == $past(PC_HIGH_LATCH_I[LATCH_HI:LATCH_LO])
    ) else $error("Jump target was not built from immediate and latch.");

    chk_jump_two_slots: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_JUMP
        |=> $stable(ZERO_FLAG_O) && $stable(ACC_O) ##(SLOT_WAIT - 1) NOP_SLOT_O
            ##1 $stable(PC_O)
    ) else $error("Jump did not take two slots or touched a flag.");

    chk_or_literal: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_OR_LIT
        |=> ACC_O == ($past(ACC_O) | $past(LITERAL_I[DATA_W-1:0]))
            && ZERO_FLAG_O == (ACC_O == DATA_ZERO) && !FILE_WE_O
    ) else $error("OR-literal result or zero flag is wrong.");

    chk_or_file_route: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_OR_FILE && DEST_SEL_I == DEST_FILE
        |=> FILE_WE_O && FILE_WDATA_O == ($past(ACC_O) | $past(FILE_RDATA_I))
            && ZERO_FLAG_O == (FILE_WDATA_O == DATA_ZERO) && $stable(ACC_O)
    ) else $error("OR-with-file result did not reach the file register.");

    chk_or_file_acc: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_OR_FILE && DEST_SEL_I == DEST_ACC
        |=> !FILE_WE_O && ACC_O == ($past(ACC_O) | $past(FILE_RDATA_I))
            && ZERO_FLAG_O == (ACC_O == DATA_ZERO)
    ) else $error("OR-with-file result did not reach the accumulator.");

    chk_write_pulse: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        FILE_WE_O |=> !FILE_WE_O
    ) else $error("File write strobe lasted more than one cycle.");

    chk_tick_period: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        INSTR_TICK_O |=> !INSTR_TICK_O ##(SLOT_WAIT - 1) INSTR_TICK_O
    ) else $error("Instruction slots are not evenly spaced.");

    chk_skip_slot_step: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        NOP_SLOT_O && s_q.state == ST_SKIP_NOP
        |=> PC_O == $past(PC_O) + PC_STEP && $stable(ACC_O) && $stable(ZERO_FLAG_O)
            && !FILE_WE_O
    ) else $error("Skipped slot did not advance the program counter alone.");

    chk_jump_slot_hold: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        NOP_SLOT_O && s_q.state == ST_JUMP_NOP
        |=> $stable(PC_O) && $stable(ACC_O) && $stable(ZERO_FLAG_O) && !FILE_WE_O
    ) else $error("Jump slot changed state it should leave alone.");

    chk_jump_no_write: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_JUMP
        |=> !FILE_WE_O
    ) else $error("Jump wrote a file register.");

    chk_dec_keeps_zero: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_DEC_SKIP
        |=> $stable(ZERO_FLAG_O)
    ) else $error("Decrement-skip changed the zero flag.");

    chk_inc_to_file: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_INC_FILE && DEST_SEL_I == DEST_FILE
        |=> FILE_WE_O && FILE_WADDR_O == $past(FILE_ADDR_I)
            && FILE_WDATA_O == $past(FILE_RDATA_I) + DATA_ONE && $stable(ACC_O)
    ) else $error("Increment result did not reach the file register.");

    chk_inc_to_acc: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I == OP_INC_FILE && DEST_SEL_I == DEST_ACC
        |=> !FILE_WE_O && ACC_O == $past(FILE_RDATA_I) + DATA_ONE
    ) else $error("Increment result did not reach the accumulator.");

    chk_zero_held: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        !(accept && EXEC_VALID_I
          && (OPCODE_I == OP_INC_FILE || OPCODE_I == OP_OR_LIT || OPCODE_I == OP_OR_FILE))
        |=> $stable(ZERO_FLAG_O)
    ) else $error("Zero flag changed without a flag-updating instruction.");

    chk_pc_next: assert property (
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
        accept && EXEC_VALID_I && OPCODE_I != OP_JUMP
        |=> PC_O == $past(PC_O) + PC_STEP
    ) else $error("Program counter did not step to the next instruction.");

endmodule : incdec_exec

// ==== dv/test_incdec_skip_branch_or_exec.sv ====
// Self-checking testbench for the increment, skip, jump and OR executor.
`timescale 1ns/1ns
`define CHK(got, exp, what) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("FAIL %0t %s got %0h exp %0h", $time, what, got, exp); \
        end \
    end
module test_incdec_skip_branch_or_exec
    import incdec_pkg::*;
;
    typedef struct packed {
        logic [OP_W-1:0]    op;
        logic               dst;
        logic [FADDR_W-1:0] fa;
        logic [JUMP_W-1:0]  lit;
        logic [LATCH_W-1:0] hl;
        logic [DATA_W-1:0]  fr;
        logic [DATA_W-1:0]  acc;
        logic               z;
        logic               we;
        logic [DATA_W-1:0]  wd;
        logic [PC_W-1:0]    pc;
        logic               nop;
    } incdec_row_t;

    // Each row is one instruction with the state expected one clock after it is taken.
    localparam incdec_row_t ROWS [17] = '{
        '{OP_INC_FILE,1'b1,7'h41,11'h000,7'h00,8'h41,8'h00,1'b0,1'b1,8'h42,15'h0001,1'b0},
        '{OP_INC_FILE,1'b0,7'h7f,11'h000,7'h00,8'hff,8'h00,1'b1,1'b0,8'h00,15'h0002,1'b0},
        '{OP_OR_LIT,1'b0,7'h00,11'h7a5,7'h00,8'h00,8'ha5,1'b0,1'b0,8'h00,15'h0003,1'b0},
        '{OP_OR_LIT,1'b0,7'h00,11'h100,7'h00,8'hff,8'ha5,1'b0,1'b0,8'h00,15'h0004,1'b0},
        '{OP_DEC_SKIP,1'b0,7'h10,11'h000,7'h00,8'h02,8'h01,1'b0,1'b0,8'h00,15'h0005,1'b0},
        '{OP_DEC_SKIP,1'b1,7'h11,11'h000,7'h00,8'h01,8'h01,1'b0,1'b1,8'h00,15'h0006,1'b1},
        '{OP_INC_SKIP,1'b0,7'h12,11'h000,7'h00,8'hff,8'h00,1'b0,1'b0,8'h00,15'h0008,1'b1},
        '{OP_INC_SKIP,1'b1,7'h13,11'h000,7'h00,8'h7f,8'h00,1'b0,1'b1,8'h80,15'h000a,1'b0},
        '{OP_OR_FILE,1'b0,7'h14,11'h000,7'h00,8'h00,8'h00,1'b1,1'b0,8'h00,15'h000b,1'b0},
        '{OP_OR_FILE,1'b1,7'h7f,11'h000,7'h00,8'h3c,8'h00,1'b0,1'b1,8'h3c,15'h000c,1'b0},
        '{OP_OR_FILE,1'b0,7'h00,11'h000,7'h00,8'h81,8'h81,1'b0,1'b0,8'h00,15'h000d,1'b0},
        '{OP_JUMP,1'b0,7'h00,11'h5ab,7'h5d,8'h00,8'h81,1'b0,1'b0,8'h00,15'h5dab,1'b1},
        '{OP_INC_FILE,1'b0,7'h20,11'h000,7'h00,8'h10,8'h11,1'b0,1'b0,8'h00,15'h5dac,1'b0},
        '{OP_INC_FILE,1'b1,7'h21,11'h000,7'h00,8'hff,8'h11,1'b1,1'b1,8'h00,15'h5dad,1'b0},
        '{OP_JUMP,1'b1,7'h00,11'h7ff,7'h07,8'h00,8'h11,1'b1,1'b0,8'h00,15'h07ff,1'b1},
        '{3'h7,1'b0,7'h00,11'h000,7'h00,8'h00,8'h11,1'b1,1'b0,8'h00,15'h0800,1'b0},
        '{OP_DEC_SKIP,1'b1,7'h7f,11'h000,7'h00,8'h00,8'h11,1'b1,1'b1,8'hff,15'h0801,1'b0}
    };

    logic                ref_clk;
    logic                rst_n;
    logic                exec_valid;
    logic [OP_W-1:0]     opcode;
    logic [FADDR_W-1:0]  file_addr;
    logic                dest_sel;
    logic [JUMP_W-1:0]   literal;
    logic [DATA_W-1:0]   file_rdata;
    logic [LATCH_W-1:0]  pc_high_latch;
    logic                instr_tick;
    logic                instr_accept;
    logic                nop_slot;
    logic [DATA_W-1:0]   acc;
    logic                zero_flag;
    logic [PC_W-1:0]     pc;
    logic                file_we;
    logic [FADDR_W-1:0]  file_waddr;
    logic [DATA_W-1:0]   file_wdata;
    int                  bad_count;
    int                  cmp_count;
    int                  prev_nop;
    int                  wait_n;

    incdec_exec #(.CLKS_PER_SLOT(CLKS_PER_INSTR)) incdec_exec_inst (
        .REF_CLK_I       (ref_clk),
        .RST_N_I         (rst_n),
        .EXEC_VALID_I    (exec_valid),
        .OPCODE_I        (opcode),
        .FILE_ADDR_I     (file_addr),
        .DEST_SEL_I      (dest_sel),
        .LITERAL_I       (literal),
        .FILE_RDATA_I    (file_rdata),
        .PC_HIGH_LATCH_I (pc_high_latch),
        .INSTR_TICK_O    (instr_tick),
        .INSTR_ACCEPT_O  (instr_accept),
        .NOP_SLOT_O      (nop_slot),
        .ACC_O           (acc),
        .ZERO_FLAG_O     (zero_flag),
        .PC_O            (pc),
        .FILE_WE_O       (file_we),
        .FILE_WADDR_O    (file_waddr),
        .FILE_WDATA_O    (file_wdata)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // Presents one instruction at a falling edge and checks the state after it is taken.
    task automatic run_row(input incdec_row_t r);
        int n;
        int nops;
        nops = 0;
        exec_valid = 1'b1;
        opcode = r.op;
        dest_sel = r.dst;
        file_addr = r.fa;
        literal = r.lit;
        pc_high_latch = r.hl;
        file_rdata = r.fr;
        for (n = 0; n < 40 && instr_accept !== 1'b1; n++) begin
            @(negedge ref_clk);
            if (nop_slot === 1'b1) begin
                nops++;
            end
        end
        if (instr_accept !== 1'b1) begin
            bad_count++;
            $display("FAIL %0t no accept slot", $time);
            tally_and_finish();
        end
        `CHK(nops, prev_nop, "nop slots")
        @(negedge ref_clk);
        `CHK(acc, r.acc, "acc")
        `CHK(zero_flag, r.z, "zero")
        `CHK(pc, r.pc, "pc")
        `CHK(file_we, r.we, "we")
        if (r.we) begin
            `CHK(file_waddr, r.fa, "waddr")
            `CHK(file_wdata, r.wd, "wdata")
        end
        @(negedge ref_clk);
        `CHK(file_we, 1'b0, "we pulse")
        prev_nop = int'(r.nop);
    endtask : run_row

    initial begin
        bad_count = 0;
        cmp_count = 0;
        prev_nop = 0;
        rst_n = 1'b0;
        exec_valid = 1'b0;
        opcode = OP_NONE;
        file_addr = 7'h00;
        dest_sel = 1'b0;
        literal = 11'h000;
        file_rdata = 8'h00;
        pc_high_latch = 7'h00;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        foreach (ROWS[i]) begin
            run_row(ROWS[i]);
        end
        // Reset in mid-run restarts the counter and the state before the next instruction.
        rst_n = 1'b0;
        exec_valid = 1'b0;
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        prev_nop = 0;
        for (wait_n = 0; wait_n < 40 && instr_tick !== 1'b1; wait_n++) begin
            @(negedge ref_clk);
        end
        `CHK(wait_n, int'(CLKS_PER_INSTR) - 1, "first tick")
        run_row('{OP_INC_FILE,1'b0,7'h00,11'h000,7'h00,8'h00,8'h01,1'b0,1'b0,8'h00,
                  15'h0001,1'b0});
        exec_valid = 1'b0;
        `CHK(instr_tick, 1'b0, "tick pulse")
        tally_and_finish();
    end
endmodule : test_incdec_skip_branch_or_exec
